// ### dv/ccr_smb_host.sv
// Host controller model that masters SMBus word writes and reads.
`timescale 1ns/100ps
module ccr_smb_host (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tw(input int n);
      repeat (n) @(negedge clk);
   endtask : tw
   // Start and repeated start both let data fall while the clock is high.
   task automatic sta();
      sda_low = 1'b0;
      tw(4);
      scl = 1'b1;
      tw(4);
      sda_low = 1'b1;
      tw(4);
      scl = 1'b0;
   endtask : sta
   task automatic sto();
      sda_low = 1'b1;
      tw(4);
      scl = 1'b1;
      tw(4);
      sda_low = 1'b0;
      tw(4);
   endtask : sto
   task automatic bit_x(input logic b, output logic r);
      sda_low = ~b;
      tw(4);
      scl = 1'b1;
      tw(2);
      r = sda;
      tw(2);
      scl = 1'b0;
   endtask : bit_x
   task automatic byte_x(input logic [7:0] d, input logic ak, output logic [7:0] r,
                         output logic a);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r[i]);
      end
      bit_x(ak, a);
   endtask : byte_x
   task automatic write_word(input logic [6:0] adr, input logic [7:0] cmd,
                             input logic [15:0] d, output logic ok);
      logic [7:0] seq [4];
      logic [7:0] r;
      logic a;
      seq = '{{adr, 1'b0}, cmd, d[7:0], d[15:8]};
      ok = 1'b1;
      sta();
      for (int i = 0; i < 4; i++) begin
         byte_x(seq[i], 1'b1, r, a);
         ok &= ~a;
      end
      sto();
   endtask : write_word
   task automatic read_word(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
      logic [7:0] r;
      logic a;
      sta();
      byte_x({ccr_pkg::SMB_ADDR, 1'b0}, 1'b1, r, a);
      ok = ~a;
      byte_x(cmd, 1'b1, r, a);
      ok &= ~a;
      sta();
      byte_x({ccr_pkg::SMB_ADDR, 1'b1}, 1'b1, r, a);
      ok &= ~a;
      byte_x(8'hff, 1'b0, d[7:0], a);
      byte_x(8'hff, 1'b1, d[15:8], a);
      sto();
   endtask : read_word
endmodule : ccr_smb_host

// ### dv/tb_charger_control_register_bank.sv
// Self-checking testbench for the charger control register bank.
`timescale 1ns/100ps
module tb_charger_control_register_bank;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmp_above = 1'b0;
   logic bat_abs = 1'b0;
   logic ac_ok = 1'b0;
   logic rev_oc = 1'b0;
   logic scl;
   logic sda_low;
   logic smb_data_oe;
   logic throttle_alert_oe;
   logic comparator_output;
   logic limit_reload;
   logic sdo;
   logic tao;
   wire [4:0] ob;
   wire [12:0] oc;
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;
   wire sda = ~(sda_low | smb_data_oe);
   ccr_reg_bank i_dut (
      .clk, .rst_n, .smb_clk(scl), .smb_data_in(sda), .smb_data_out(sdo), .smb_data_oe,
      .comparator_input_above(cmp_above), .battery_absent(bat_abs), .adapter_present(ac_ok),
      .reverse_overcurrent(rev_oc), .comparator_ref_2v(ob[3]), .comparator_enable(ob[2]),
      .comparator_output, .severe_overcurrent_protect_en(ob[1]), .battery_ovp_en(ob[0]),
      .resistor_reread_en(oc[12]), .limit_reload, .termination_long(oc[11]),
      .charger_timeout_sel(oc[10:9]), .battery_gate_off(oc[8]),
      .system_power_monitor_gain_low(oc[7]), .ideal_diode_exit_long(oc[6]),
      .autonomous_charge_en(oc[5]), .feedback_gain_half(oc[4]), .input_limit_loop_en(oc[3]),
      .monitor_reverse(oc[2]), .switch_period_double(oc[1]), .reverse_debounce_short(ob[4]),
      .reverse_startup_short(oc[0]), .throttle_alert_out(tao), .throttle_alert_oe
   );
   ccr_smb_host i_host (.clk, .sda, .scl, .sda_low);
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         err_total++;
         end_of_test();
      end
   end
   function automatic logic [4:0] eb(input logic [15:0] b);
      return {b[13], b[4], ~b[3], ~b[1], b[0]};
   endfunction : eb
   function automatic logic [12:0] ec(input logic [15:0] c, input logic b13, input logic ba);
      return {~c[15], c[13], c[12:11], c[10:8], ~c[7], c[6], ~(c[5] | (c[4] & ba)), c[3], c[1],
              c[0] & b13};
   endfunction : ec
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tw(input int n);
      repeat (n) @(negedge clk);
   endtask : tw
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
      logic ok;
      i_host.write_word(ccr_pkg::SMB_ADDR, cmd, d, ok);
      chk("write ack", 16'h1, 16'(ok));
   endtask : wr
   task automatic rd(input logic [7:0] cmd, input logic [15:0] e);
      logic ok;
      logic [15:0] d;
      i_host.read_word(cmd, d, ok);
      chk("read ack", 16'h1, 16'(ok));
      chk("read data", e, d);
   endtask : rd
   task automatic wait_oe(input logic e, input int n);
      for (int i = 0; i < n && throttle_alert_oe !== e; i++) begin
         @(negedge clk);
      end
      chk("alert", 16'(e), 16'(throttle_alert_oe));
   endtask : wait_oe
   task automatic chk_dflt();
      chk("b outs", 16'(eb(16'h0)), 16'(ob));
      chk("c outs", 16'(ec(16'h0, 1'b0, bat_abs)), 16'(oc));
      chk("open drain levels", 16'h0, 16'({sdo, tao}));
      rd(ccr_pkg::REG_CFG_B, 16'h0);
      rd(ccr_pkg::REG_CFG_C, 16'h0);
      rd(ccr_pkg::REG_THR, 16'h0);
   endtask : chk_dflt
   task automatic t_cfg();
      logic [15:0] bv [6] = '{16'h201f, 16'h0000, 16'h2010, 16'hc00a, 16'h2005, 16'h0004};
      logic [15:0] cv [6] = '{16'hfffb, 16'h0800, 16'h1000, 16'h1801, 16'h5a51, 16'h2512};
      for (int i = 0; i < 6; i++) begin
         bat_abs = (i == 4);
         wr(ccr_pkg::REG_CFG_B, bv[i]);
         wr(ccr_pkg::REG_CFG_C, cv[i]);
         rd(ccr_pkg::REG_CFG_B, bv[i]);
         rd(ccr_pkg::REG_CFG_C, cv[i]);
         chk("b outs", 16'(eb(bv[i])), 16'(ob));
         chk("c outs", 16'(ec(cv[i], bv[i][13], bat_abs)), 16'(oc));
      end
      bat_abs = 1'b0;
      for (int i = 0; i < 8; i++) begin
         wr(ccr_pkg::REG_CFG_B, {12'h0, i[2:1], 2'b00});
         cmp_above = i[0];
         tw(3);
         chk("comparator", 16'((i[0] ^ i[1]) & ~i[2]), 16'(comparator_output));
      end
      cmp_above = 1'b0;
      $display("Test config done");
   endtask : t_cfg
   task automatic t_reload();
      int n;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         wr(ccr_pkg::REG_CFG_C, {1'b0, k[0], 14'h0});
         ac_ok = 1'b0;
         tw(3);
         ac_ok = 1'b1;
         repeat (6) begin
            @(negedge clk);
            n += (limit_reload === 1'b1);
         end
         chk("reload pulses", 16'(1 - k), 16'(n));
      end
      wr(ccr_pkg::REG_CFG_B, 16'h201f);
      wr(ccr_pkg::REG_THR, 16'h00f1);
      wr(ccr_pkg::REG_CFG_C, 16'h8c84);
      chk_dflt();
      $display("Test reload and digital reset done");
   endtask : t_reload
   task automatic t_map();
      logic ok;
      wr(ccr_pkg::REG_THR, 16'hff41);
      rd(ccr_pkg::REG_THR, 16'h0041);
      wr(8'h50, 16'h1234);
      rd(8'h50, 16'h0000);
      i_host.write_word(7'h13, ccr_pkg::REG_THR, 16'h0000, ok);
      chk("foreign address ack", 16'h0, 16'(ok));
      rd(ccr_pkg::REG_THR, 16'h0041);
      $display("Test map done");
   endtask : t_map
   task automatic t_trig();
      logic [15:0] v;
      for (int k = 0; k < 4; k++) begin
         v = 16'h0001 | (16'h0010 << k);
         wr(ccr_pkg::REG_THR, v);
         case (k)
            0: cmp_above = 1'b1;
            1: ac_ok = 1'b0;
            2: bat_abs = 1'b1;
            default: rev_oc = 1'b1;
         endcase
         wait_oe(1'b1, 200);
         {cmp_above, ac_ok, bat_abs, rev_oc} = 4'b0100;
         tw(200);
         chk("alert held", 16'h1, 16'(throttle_alert_oe));
         wr(ccr_pkg::REG_THR, v | 16'h0002);
         chk("alert cleared", 16'h0, 16'(throttle_alert_oe));
         rd(ccr_pkg::REG_THR, v);
      end
      $display("Test triggers done");
   endtask : t_trig
   task automatic t_deb();
      int lim [4] = '{ccr_pkg::DEB_US_0, ccr_pkg::DEB_US_1, ccr_pkg::DEB_US_2, ccr_pkg::DEB_US_3};
      for (int d = 0; d < 4; d++) begin
         wr(ccr_pkg::REG_THR, 16'h0040 | 16'(d << 2));
         bat_abs = 1'b1;
         tw(lim[d] * int'(ccr_pkg::TICK_CYC) + 1);
         chk("alert early", 16'h0, 16'(throttle_alert_oe));
         wait_oe(1'b1, 48);
         bat_abs = 1'b0;
         wait_oe(1'b0, 8);
      end
      $display("Test debounce done");
   endtask : t_deb
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      tw(2);
      chk_dflt();
      t_cfg();
      t_reload();
      t_map();
      t_trig();
      t_deb();
      end_of_test();
   end
endmodule : tb_charger_control_register_bank

// ### logic/ccr_alert.sv
// Throttle alert unit: trigger enables, debounce, auto-clear and latch.
`timescale 1ns/100ps
module ccr_alert (
   input wire logic clk,
   input wire logic rst_n,
   ccr_alert_if.unit ai
);
   typedef struct packed {
      logic [7:0] cnt;
      logic cmp_prev;
      logic latched;
      logic alert;
   } ccr_alert_s;
   ccr_alert_s q, d;
   logic db_raw;
   logic db_ok;
   logic trip;

   function automatic logic [7:0] deb_limit(input logic [1:0] sel);
      case (sel)
         2'h0: deb_limit = ccr_pkg::DEB_US_0;
         2'h1: deb_limit = ccr_pkg::DEB_US_1;
         2'h2: deb_limit = ccr_pkg::DEB_US_2;
         default: deb_limit = ccr_pkg::DEB_US_3;
      endcase
   endfunction : deb_limit

   always_comb begin
      d = q;
      db_raw = (ai.trig_en[2] & ai.bat_absent) | (ai.trig_en[1] & ~ai.adapter_present);
      db_ok = db_raw && (q.cnt > deb_limit(ai.deb_sel));
      trip = (ai.trig_en[3] & ai.rev_oc) | db_ok | (ai.trig_en[0] & ai.cmp_out & ~q.cmp_prev);
      d.cmp_prev = ai.cmp_out;
      if (!db_raw) begin
         d.cnt = 8'h00;
      end else if (ai.us_tick && q.cnt != 8'hff) begin
         d.cnt = q.cnt + 8'h01;
      end
      // A trip in the clearing cycle wins over the clear.
      d.latched = ai.latch_en & (trip | (q.latched & ~ai.clear));
      d.alert = trip | d.latched;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign ai.alert = q.alert;

   AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      (ai.latch_en && q.alert && !ai.clear) |=> (q.alert || !ai.latch_en))
      else $error("latched alert dropped without clear");
   AST_CLEAR_DROP: assert property (@(posedge clk) disable iff (!rst_n)
      (q.latched && ai.clear && !trip) |=> !q.latched)
      else $error("alert clear did not release the latch");
   AST_DEB_TIME: assert property (@(posedge clk) disable iff (!rst_n)
      (db_ok && !$past(db_ok)) |-> q.cnt == deb_limit(ai.deb_sel) + 8'h01)
      else $error("debounce trip at wrong count");
endmodule : ccr_alert

// ### logic/ccr_reg_bank.sv
// Charger control register bank with its SMBus slave and decoded control outputs.
`timescale 1ns/100ps
module ccr_reg_bank (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic smb_clk,
   input wire logic smb_data_in,
   output logic smb_data_out,
   output logic smb_data_oe,
   input wire logic comparator_input_above,
   input wire logic battery_absent,
   input wire logic adapter_present,
   input wire logic reverse_overcurrent,
   output logic comparator_ref_2v,
   output logic comparator_enable,
   output logic comparator_output,
   output logic severe_overcurrent_protect_en,
   output logic battery_ovp_en,
   output logic resistor_reread_en,
   output logic limit_reload,
   output logic termination_long,
   output logic [1:0] charger_timeout_sel,
   output logic battery_gate_off,
   output logic system_power_monitor_gain_low,
   output logic ideal_diode_exit_long,
   output logic autonomous_charge_en,
   output logic feedback_gain_half,
   output logic input_limit_loop_en,
   output logic monitor_reverse,
   output logic switch_period_double,
   output logic reverse_debounce_short,
   output logic reverse_startup_short,
   output logic throttle_alert_out,
   output logic throttle_alert_oe
);
   typedef struct packed {
      ccr_pkg::ccr_st_e st;
      logic scl_q;
      logic sda_q;
      logic [7:0] sh;
      logic [3:0] bitc;
      logic [1:0] byte_n;
      logic rw;
      logic [7:0] cmd;
      logic [7:0] wlo;
      logic [7:0] txb;
      logic tx_hi;
      logic oe;
      logic [15:0] cfg_b;
      logic [15:0] cfg_c;
      logic [7:0] thr;
      logic clr;
      logic ap_q;
      logic reload;
      logic cmp;
   } ccr_bank_s;
   ccr_bank_s q, d;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic wr_en;
   logic [7:0] wr_cmd;
   logic [15:0] wr_data;
   logic us_tick;
   logic [15:0] rd_val;

   ccr_alert_if ai ();

   // Read word for a command code; unmapped codes read zero.
   function automatic logic [15:0] rd_word(input logic [7:0] c, input logic [15:0] b,
                                           input logic [15:0] cc, input logic [7:0] t);
      case (c)
         ccr_pkg::REG_CFG_B: rd_word = b;
         ccr_pkg::REG_CFG_C: rd_word = cc;
         ccr_pkg::REG_THR: rd_word = {8'h00, t};
         default: rd_word = 16'h0000;
      endcase
   endfunction : rd_word

   always_comb begin
      d = q;
      d.scl_q = smb_clk;
      d.sda_q = smb_data_in;
      d.clr = 1'b0;
      d.reload = 1'b0;
      wr_en = 1'b0;
      wr_cmd = q.cmd;
      wr_data = {q.sh, q.wlo};
      rd_val = rd_word(q.cmd, q.cfg_b, q.cfg_c, q.thr);
      scl_rise = ~q.scl_q & smb_clk;
      scl_fall = q.scl_q & ~smb_clk;
      start_c = q.scl_q & smb_clk & q.sda_q & ~smb_data_in;
      stop_c = q.scl_q & smb_clk & ~q.sda_q & smb_data_in;
      if (start_c) begin
         d.st = ccr_pkg::ST_RX;
         d.bitc = 4'h0;
         d.byte_n = 2'h0;
         d.oe = 1'b0;
      end else if (stop_c) begin
         d.st = ccr_pkg::ST_IDLE;
         d.oe = 1'b0;
      end else begin
         case (q.st)
            ccr_pkg::ST_IDLE: begin
               d.oe = 1'b0;
            end
            ccr_pkg::ST_RX: begin
               if (scl_rise && q.bitc != 4'h8) begin
                  d.sh = {q.sh[6:0], smb_data_in};
                  d.bitc = q.bitc + 4'h1;
               end else if (scl_fall && q.bitc == 4'h8) begin
                  d.bitc = 4'h0;
                  d.st = ccr_pkg::ST_ACK;
                  d.oe = 1'b1;
                  if (q.byte_n != 2'h3) begin
                     d.byte_n = q.byte_n + 2'h1;
                  end
                  case (q.byte_n)
                     2'h0: begin
                        d.rw = q.sh[0];
                        if (q.sh[7:1] != ccr_pkg::SMB_ADDR) begin
                           d.st = ccr_pkg::ST_IDLE;
                           d.oe = 1'b0;
                        end
                     end
                     2'h1: d.cmd = q.sh;
                     2'h2: d.wlo = q.sh;
                     default: wr_en = 1'b1;
                  endcase
               end
            end
            ccr_pkg::ST_ACK: begin
               if (scl_fall) begin
                  if (q.rw) begin
                     d.txb = rd_val[7:0];
                     d.oe = ~d.txb[7];
                     d.tx_hi = 1'b0;
                     d.st = ccr_pkg::ST_TX;
                  end else begin
                     d.oe = 1'b0;
                     d.st = ccr_pkg::ST_RX;
                  end
               end
            end
            ccr_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (q.bitc == 4'h7) begin
                     d.bitc = 4'h0;
                     d.oe = 1'b0;
                     d.st = ccr_pkg::ST_MACK;
                  end else begin
                     d.bitc = q.bitc + 4'h1;
                     d.txb = {q.txb[6:0], 1'b0};
                     d.oe = ~q.txb[6];
                  end
               end
            end
            ccr_pkg::ST_MACK: begin
               if (scl_rise) begin
                  if (smb_data_in) begin
                     d.st = ccr_pkg::ST_IDLE;
                  end else begin
                     d.txb = q.tx_hi ? 8'h00 : rd_val[15:8];
                     d.tx_hi = 1'b1;
                     d.st = ccr_pkg::ST_TXS;
                  end
               end
            end
            ccr_pkg::ST_TXS: begin
               if (scl_fall) begin
                  d.oe = ~q.txb[7];
                  d.st = ccr_pkg::ST_TX;
               end
            end
            default: begin
               d.st = ccr_pkg::ST_IDLE;
               d.oe = 1'b0;
            end
         endcase
      end
      if (wr_en) begin
         case (wr_cmd)
            ccr_pkg::REG_CFG_B: d.cfg_b = wr_data;
            ccr_pkg::REG_CFG_C: begin
               if (wr_data[ccr_pkg::C_DRESET]) begin
                  d.cfg_b = ccr_pkg::RST_CFG_B;
                  d.cfg_c = ccr_pkg::RST_CFG_C;
                  d.thr = ccr_pkg::RST_THR;
               end else begin
                  d.cfg_c = wr_data;
               end
            end
            ccr_pkg::REG_THR: begin
               d.thr = wr_data[7:0];
               d.thr[ccr_pkg::T_CLEAR] = 1'b0;
               d.clr = wr_data[ccr_pkg::T_CLEAR];
            end
            default: d.cmd = q.cmd;
         endcase
      end
      d.ap_q = adapter_present;
      d.reload = adapter_present & ~q.ap_q & ~q.cfg_c[ccr_pkg::C_NO_RELOAD];
      // The comparator idles low while disabled.
      d.cmp = ~q.cfg_b[ccr_pkg::B_CMP_DIS] &
              (comparator_input_above ^ q.cfg_b[ccr_pkg::B_CMP_POL]);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.st <= ccr_pkg::ST_IDLE;
         q.scl_q <= 1'b1;
         q.sda_q <= 1'b1;
         q.cfg_b <= ccr_pkg::RST_CFG_B;
         q.cfg_c <= ccr_pkg::RST_CFG_C;
         q.thr <= ccr_pkg::RST_THR;
      end else begin
         q <= d;
      end
   end

   ccr_tick_div u_div (
      .clk(clk),
      .rst_n(rst_n),
      .tick(us_tick)
   );

   assign ai.trig_en = q.thr[ccr_pkg::T_EN_ROC:ccr_pkg::T_EN_CMP];
   assign ai.deb_sel = q.thr[ccr_pkg::T_DEB_LSB +: 2];
   assign ai.clear = q.clr;
   assign ai.latch_en = q.thr[ccr_pkg::T_LATCH];
   assign ai.us_tick = us_tick;
   assign ai.rev_oc = reverse_overcurrent;
   assign ai.bat_absent = battery_absent;
   assign ai.adapter_present = adapter_present;
   assign ai.cmp_out = q.cmp;

   ccr_alert u_alert (
      .clk(clk),
      .rst_n(rst_n),
      .ai(ai.unit)
   );

   assign smb_data_out = 1'b0;
   assign smb_data_oe = q.oe;
   assign throttle_alert_out = 1'b0;
   assign throttle_alert_oe = ai.alert;
   assign comparator_ref_2v = q.cfg_b[ccr_pkg::B_CMP_REF];
   assign comparator_enable = ~q.cfg_b[ccr_pkg::B_CMP_DIS];
   assign comparator_output = q.cmp;
   assign severe_overcurrent_protect_en = ~q.cfg_b[ccr_pkg::B_SOC_DIS];
   assign battery_ovp_en = q.cfg_b[ccr_pkg::B_BOVP_EN];
   assign reverse_debounce_short = q.cfg_b[ccr_pkg::B_REV_DEB];
   assign resistor_reread_en = ~q.cfg_c[ccr_pkg::C_NO_REREAD];
   assign limit_reload = q.reload;
   assign termination_long = q.cfg_c[ccr_pkg::C_TERM_LONG];
   assign charger_timeout_sel = q.cfg_c[ccr_pkg::C_TMO_LSB +: 2];
   assign battery_gate_off = q.cfg_c[ccr_pkg::C_SHIP];
   assign system_power_monitor_gain_low = q.cfg_c[ccr_pkg::C_SYSTEM_POWER_MONITOR_GAIN];
   assign ideal_diode_exit_long = q.cfg_c[ccr_pkg::C_IDM_LONG];
   assign autonomous_charge_en = ~q.cfg_c[ccr_pkg::C_HOST_CHG];
   assign feedback_gain_half = q.cfg_c[ccr_pkg::C_FB_HALF];
   assign input_limit_loop_en = ~(q.cfg_c[ccr_pkg::C_ILIM_DIS] |
      (q.cfg_c[ccr_pkg::C_ILIM_BG_DIS] & battery_absent));
   assign monitor_reverse = q.cfg_c[ccr_pkg::C_MON_REV];
   assign switch_period_double = q.cfg_c[ccr_pkg::C_PERIOD];
   assign reverse_startup_short = q.cfg_c[ccr_pkg::C_START_SHORT] &
                                  q.cfg_b[ccr_pkg::B_REV_DEB];

   sequence s_dreset_wr;
      wr_en && wr_cmd == ccr_pkg::REG_CFG_C && wr_data[ccr_pkg::C_DRESET];
   endsequence
   sequence s_defaults;
      q.cfg_b == ccr_pkg::RST_CFG_B && q.cfg_c == ccr_pkg::RST_CFG_C &&
      q.thr == ccr_pkg::RST_THR;
   endsequence

   AST_DRESET: assert property (@(posedge clk) disable iff (!rst_n)
      s_dreset_wr |=> s_defaults)
      else $error("digital reset did not restore defaults");
   AST_SELF_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
      !q.cfg_c[ccr_pkg::C_DRESET] && !q.thr[ccr_pkg::T_CLEAR])
      else $error("action bit stayed set");
   AST_CLR_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en && wr_cmd == ccr_pkg::REG_THR && wr_data[ccr_pkg::T_CLEAR]) |=> q.clr ##1 !q.clr)
      else $error("alert clear pulse wrong");
   AST_THR_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
      (q.st == ccr_pkg::ST_MACK && scl_rise && !smb_data_in && !q.tx_hi &&
       q.cmd == ccr_pkg::REG_THR) |=> q.txb == 8'h00)
      else $error("throttle register upper byte not zero");
   AST_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(adapter_present) |=> limit_reload == !$past(q.cfg_c[ccr_pkg::C_NO_RELOAD]))
      else $error("limit reload pulse wrong");
   AST_ILIM: assert property (@(posedge clk) disable iff (!rst_n)
      (q.cfg_c[ccr_pkg::C_ILIM_DIS] || (q.cfg_c[ccr_pkg::C_ILIM_BG_DIS] && battery_absent))
      |-> !input_limit_loop_en)
      else $error("input limit loop left enabled");
   AST_CMP_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      q.cfg_b[ccr_pkg::B_CMP_DIS] [*2] |-> !comparator_output)
      else $error("disabled comparator drives output");
   AST_STARTUP: assert property (@(posedge clk) disable iff (!rst_n)
      reverse_startup_short |-> reverse_debounce_short)
      else $error("start-up shortened without 150 ms debounce");
endmodule : ccr_reg_bank

// ### logic/ccr_tick_div.sv
// Divider that makes a one-cycle pulse every microsecond.
`timescale 1ns/100ps
module ccr_tick_div (
   input wire logic clk,
   input wire logic rst_n,
   output logic tick
);
   typedef struct packed {
      logic [5:0] cnt;
      logic tick;
   } ccr_div_s;
   ccr_div_s q, d;

   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (q.cnt == ccr_pkg::TICK_CYC - 6'h01) begin
         d.cnt = 6'h00;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 6'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = q.tick;
endmodule : ccr_tick_div

// ### pkg/ccr_alert_if.sv
// Interface between the register bank and the throttle alert unit.
`timescale 1ns/100ps
interface ccr_alert_if;
   logic [3:0] trig_en;
   logic [1:0] deb_sel;
   logic clear;
   logic latch_en;
   logic us_tick;
   logic rev_oc;
   logic bat_absent;
   logic adapter_present;
   logic cmp_out;
   logic alert;
   modport bank (output trig_en, deb_sel, clear, latch_en, us_tick, rev_oc, bat_absent,
                 adapter_present, cmp_out, input alert);
   modport unit (input trig_en, deb_sel, clear, latch_en, us_tick, rev_oc, bat_absent,
                 adapter_present, cmp_out, output alert);
endinterface : ccr_alert_if

// ### pkg/ccr_pkg.sv
// Package with register map, field positions, reset values and timing counts of the bank.
// How it works
// - Reference select bit chooses 1.2 V (0) or 2 V (1) for the comparator.
// - Comparator disable bit: 0 keeps the comparator on, 1 turns it off.
// - Polarity bit: 0 output high when input above reference, 1 output low.
// - Severe overcurrent protection is on at 0 and off at 1.
// - Battery overvoltage protection is off at 0 and on at 1.
// - Reread bit 0 rereads the configuration resistor, 1 suppresses it.
// - Reload bit 0 reloads adapter limit one on adapter plug-in, 1 suppresses.
// - Termination time bit picks 20 ms (0) or 200 ms (1).
// - Two-bit timeout field picks 175 s, 87.5 s, 43.75 s or 5 s.
// - Ship mode bit 1 forces the battery gate off.
// - Diode-mode exit timer picks 40 ms (0) or 80 ms (1).
// - Autonomous charging bit: 0 autonomous, 1 host controls charge current.
// - Bit 5 disables input limit loop; bit 4 disables it while battery absent.
// - Monitor direction bit: 0 forward or charging, 1 reverse or discharging current.
// - Writing 1 to digital reset returns all registers to power-on defaults.
// - Switching period bit 1 doubles the buck-boost switching period.
// - Start-up bit shortens reverse start-up to 1 ms when 150 ms debounce chosen.
// - Bits 7 to 4 enable alert triggers: reverse overcurrent, battery, adapter, comparator.
// - Debounce field picks 2, 25, 125 or 250 us before adapter/battery trip.
// - Writing 1 to alert clear clears an asserted throttle alert.
// - Latch bit 0 auto-clears the alert, 1 holds it until cleared.
// - Monitor gain bit picks 1.44 (0) or 0.723 (1) microamps per watt.
// - Second-register bit 13 picks 1.3 s (0) or 150 ms (1) reverse debounce.
package ccr_pkg;
   localparam logic [6:0] SMB_ADDR = 7'h12;
   localparam logic [7:0] REG_CFG_B = 8'h3d;
   localparam logic [7:0] REG_CFG_C = 8'h4c;
   localparam logic [7:0] REG_THR = 8'h4e;
   localparam logic [15:0] RST_CFG_B = 16'h0000;
   localparam logic [15:0] RST_CFG_C = 16'h0000;
   localparam logic [7:0] RST_THR = 8'h00;
   localparam int B_REV_DEB = 13;
   localparam int B_CMP_REF = 4;
   localparam int B_CMP_DIS = 3;
   localparam int B_CMP_POL = 2;
   localparam int B_SOC_DIS = 1;
   localparam int B_BOVP_EN = 0;
   localparam int C_NO_REREAD = 15;
   localparam int C_NO_RELOAD = 14;
   localparam int C_TERM_LONG = 13;
   localparam int C_TMO_LSB = 11;
   localparam int C_SHIP = 10;
   localparam int C_SYSTEM_POWER_MONITOR_GAIN = 9;
   localparam int C_IDM_LONG = 8;
   localparam int C_HOST_CHG = 7;
   localparam int C_FB_HALF = 6;
   localparam int C_ILIM_DIS = 5;
   localparam int C_ILIM_BG_DIS = 4;
   localparam int C_MON_REV = 3;
   localparam int C_DRESET = 2;
   localparam int C_PERIOD = 1;
   localparam int C_START_SHORT = 0;
   localparam int T_EN_ROC = 7;
   localparam int T_EN_BAT = 6;
   localparam int T_EN_AC = 5;
   localparam int T_EN_CMP = 4;
   localparam int T_DEB_LSB = 2;
   localparam int T_CLEAR = 1;
   localparam int T_LATCH = 0;
   localparam int CLK_MHZ = 40;
   localparam int TICK_US = 1;
   localparam logic [5:0] TICK_CYC = 6'(TICK_US * CLK_MHZ);
   localparam logic [7:0] DEB_US_0 = 8'd2;
   localparam logic [7:0] DEB_US_1 = 8'd25;
   localparam logic [7:0] DEB_US_2 = 8'd125;
   localparam logic [7:0] DEB_US_3 = 8'd250;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_RX = 6'h02,
      ST_ACK = 6'h04,
      ST_TX = 6'h08,
      ST_MACK = 6'h10,
      ST_TXS = 6'h20
   } ccr_st_e;
endpackage : ccr_pkg
